// ==== tb/sbes_host.sv ====
// Host model: bus controller issuing decoded commands and taking answers.
// Assumes queries are answered on the cycle after the command is taken.
`timescale 1ns/10ps
module sbes_host
    import sbes_pkg::*;
(
    // Clock
    input  wire logic       clk,
    // Command side
    output sbes_cmd_t       cmd_code,
    output logic            cmd_valid,
    output logic [7:0]      cmd_data,
    // Answer side
    input  wire logic       resp_valid,
    input  wire logic [7:0] resp_data
);
    // Idle command port
    initial
    begin
        cmd_valid = 1'b0;
        cmd_code  = SBES_CMD_CLS;
        cmd_data  = 8'h00;
    end

    // One command per message; no answer leaves r unknown
    task automatic send(input sbes_cmd_t c, input logic [7:0] d, output logic [7:0] r);
        r = 'x;
        @(posedge clk);
        cmd_code  <= c;
        cmd_data  <= d;
        cmd_valid <= 1'b1;
        @(posedge clk);
        cmd_valid <= 1'b0;
        repeat (2)
        begin
            @(posedge clk);
            if (resp_valid === 1'b1)
                r = resp_data;
        end
    endtask
endmodule

// ==== tb/status_byte_event_summary_tb.sv ====
// Self-checking bench for the status byte and standard event core.
// Assumes the host model drives commands; strobes and levels come from here.
`timescale 1ns/10ps
module status_byte_event_summary_tb
    import sbes_pkg::*;
;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        clk;
    logic        rst_n;
    logic [5:0]  lv;
    logic [6:0]  strb;
    logic [15:0] err_num;
    logic        cmd_valid, resp_valid, service_request, clear_status, pending_op;
    sbes_cmd_t   cmd_code;
    logic [7:0]  cmd_data, resp_data, status_byte, r;
    int          bad_count, n_tests, n_clear;
    logic [10:0] rows [5] = '{{3'b000, 8'h00}, {3'b100, 8'h08}, {3'b010, 8'h80},
                              {3'b001, 8'h10}, {3'b111, 8'h98}};
    int          errs [8] = '{-400, -499, -300, -399, 2000, -200, -299, -250};

    sbes_host host_u (.clk(clk), .cmd_code(cmd_code), .cmd_valid(cmd_valid),
        .cmd_data(cmd_data), .resp_valid(resp_valid), .resp_data(resp_data));

    sbes_core dut_u (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_data(cmd_data), .ques_summary(lv[5]),
        .oper_summary(lv[4]), .queue_not_empty(lv[3]), .err_valid(strb[6]),
        .err_num(err_num), .queue_err(strb[5]), .command_err(strb[4]),
        .auto_count_on(lv[2]), .stats_on(lv[1]), .func_tot_peak(lv[0]),
        .meas_start(strb[3]), .meas_end(strb[2]), .block_start(strb[1]),
        .block_last_done(strb[0]), .resp_valid(resp_valid), .resp_data(resp_data),
        .status_byte(status_byte), .service_request(service_request),
        .clear_status(clear_status), .pending_op(pending_op));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Counts cycles in which the clear pulse stands
    always @(posedge clk)
        if (clear_status === 1'b1)
            n_clear <= n_clear + 1;

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Query and compare the answer
    task automatic rd(input sbes_cmd_t c, input logic [7:0] exp);
        host_u.send(c, 8'h00, r);
        chk(r, exp);
    endtask

    // One-cycle strobe, then let summaries settle
    task automatic pulse(input int i);
        @(posedge clk);
        strb[i] <= 1'b1;
        @(posedge clk);
        strb <= '0;
        cyc(3);
    endtask

    task automatic finish_test;
        $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Clock and watchdog
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial
    begin
        cyc(5000);
        bad_count++;
        finish_test;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        rst_n = 1'b0; lv = '0; strb = '0; err_num = 16'h0000;
        bad_count = 0; n_tests = 0; n_clear = 0;
        cyc(6);
        chk(status_byte, 8'h00);
        rst_n <= 1'b1;
        // Summary levels table
        foreach (rows[i])
        begin
            @(posedge clk);
            lv[5:3] <= rows[i][10:8];
            cyc(3);
            chk(status_byte, rows[i][7:0]);
        end
        lv <= '0;
        rd(SBES_CMD_ESR_R, 8'h80);
        rd(SBES_CMD_ESR_R, 8'h00);
        rd(SBES_CMD_SRE_R, 8'h00);
        rd(SBES_CMD_ESE_R, 8'h00);
        host_u.send(SBES_CMD_ESE_W, 8'hFF, r);
        rd(SBES_CMD_ESE_R, 8'hBD);
        // Error number classes at their bounds
        foreach (errs[i])
        begin
            err_num <= errs[i][15:0];
            pulse(6);
            chk(8'(status_byte[5]), 8'h01);
            rd(SBES_CMD_ESR_R, errs[i] <= -400 ? 8'h04 : (errs[i] <= -300 || errs[i] > 0)
                ? 8'h08 : 8'h10);
            cyc(3);
            chk(status_byte, 8'h00);
        end
        pulse(5);
        rd(SBES_CMD_ESR_R, 8'h04);
        pulse(4);
        rd(SBES_CMD_ESR_R, 8'h20);
        // Service request, poll and query
        host_u.send(SBES_CMD_SRE_W, 8'hFF, r);
        rd(SBES_CMD_SRE_R, 8'hB8);
        lv[3] <= 1'b1;
        cyc(3);
        chk(8'(service_request), 8'h01);
        rd(SBES_CMD_STB_R, 8'h50);
        rd(SBES_CMD_STB_R, 8'h50);
        rd(SBES_CMD_SPOLL, 8'h50);
        rd(SBES_CMD_SPOLL, 8'h10);
        host_u.send(SBES_CMD_SRE_W, 8'h08, r);
        cyc(3);
        chk(8'(service_request), 8'h00);
        lv[5] <= 1'b1;
        cyc(3);
        chk(8'(service_request), 8'h01);
        host_u.send(SBES_CMD_SRE_W, 8'h00, r);
        cyc(3);
        chk(8'(service_request), 8'h00);
        chk(status_byte, 8'h18);
        lv <= '0;
        // Operation complete, idle and pending
        host_u.send(SBES_CMD_OPC, 8'h00, r);
        cyc(3);
        rd(SBES_CMD_ESR_R, 8'h01);
        pulse(3);
        chk(8'(pending_op), 8'h01);
        host_u.send(SBES_CMD_OPC, 8'h00, r);
        cyc(3);
        rd(SBES_CMD_ESR_R, 8'h00);
        pulse(2);
        chk(8'(pending_op), 8'h00);
        rd(SBES_CMD_ESR_R, 8'h01);
        lv[2:1] <= 2'b11;
        pulse(1);
        pulse(2);
        chk(8'(pending_op), 8'h01);
        pulse(0);
        chk(8'(pending_op), 8'h00);
        // Totalize or peak function keeps per-cycle mode
        lv[0] <= 1'b1;
        pulse(3);
        chk(8'(pending_op), 8'h01);
        pulse(2);
        chk(8'(pending_op), 8'h00);
        // Clear status
        pulse(4);
        host_u.send(SBES_CMD_CLS, 8'h00, r);
        cyc(3);
        chk(status_byte, 8'h00);
        chk(8'(n_clear), 8'h01);
        rd(SBES_CMD_ESR_R, 8'h00);
        finish_test;
    end
endmodule

// ==== verilog/sbes_core.sv ====
// Status byte, service request enable and standard event summary core.
// Assumes commands arrive decoded, one per cycle, from the message parser;
// questionable, operation and output-queue summaries come in as levels.
//
// Functional notes
// - Status bit 3 follows the questionable group summary.
// - Status bit 4 is set while the output queue is not empty.
// - Status bit 5 is one when any enabled standard event is set.
// - Status bit 7 follows the operation group summary.
// - Serial poll reports the request flag in bit 6 and clears it.
// - Status query reports master summary in bit 6, clears nothing.
// - Status byte readable by serial poll or by status query.
// - Summary bits change only from their sources, never spontaneously.
// - Clear-status clears the event latch and request flag; bits 3, 4 and 7 still follow their sources.
// - Request enable mask selects summary bits that may request service.
// - Writing zero or power-on clears the request enable mask.
// - Event bits: 0 complete, 2 query, 3 device, 4 exec, 5 command, 7 power.
// - Event latch query returns then clears it; clear-status clears it too.
// - Operation complete sets at once, or when pending work ends.
// - Per-cycle mode: pending rises at measurement start, falls at its end.
// - Block mode: pending rises at block start, falls after last measurement.
// - Bit 2 on empty-queue read, lost output, errors -400 to -499.
// - Bit 3 on device failure, errors -300 to -399 and from +2000.
// - Bit 4 on bad parameter or state, errors -200 to -299.
// - Bit 5 on syntax error, unknown command, or in-message trigger.
// - Bit 7 set on power-up.
// - Event enable mask selects events for bit 5; zero or power-on clears.
`timescale 1ns/10ps
module sbes_core
    import sbes_pkg::*;
#(
    parameter int ERR_W = 16
)
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Decoded command
    input  wire logic             cmd_valid,
    input  wire sbes_cmd_t        cmd_code,
    input  wire logic [7:0]       cmd_data,
    // Summary inputs
    input  wire logic             ques_summary,
    input  wire logic             oper_summary,
    input  wire logic             queue_not_empty,
    // Error and event inputs
    input  wire logic             err_valid,
    input  wire logic [ERR_W-1:0] err_num,
    input  wire logic             queue_err,
    input  wire logic             command_err,
    // Measurement progress
    input  wire logic             auto_count_on,
    input  wire logic             stats_on,
    input  wire logic             func_tot_peak,
    input  wire logic             meas_start,
    input  wire logic             meas_end,
    input  wire logic             block_start,
    input  wire logic             block_last_done,
    // Answers
    output logic                  resp_valid,
    output logic [7:0]            resp_data,
    output logic [7:0]            status_byte,
    output logic                  service_request,
    output logic                  clear_status,
    output logic                  pending_op
);

    // ------------------------------------------------------------
    // Error number classifier
    // ------------------------------------------------------------
    function automatic logic [7:0] err_class(input logic [ERR_W-1:0] num);
        logic signed [15:0] n;
        logic [7:0]         r;
        n = 16'(signed'(num));
        r = 8'h00;
        if (n >= ERR_QRY_LO && n <= ERR_QRY_HI)
            r[EVT_QRY_POS] = 1'b1;
        if ((n >= ERR_DEV_LO && n <= ERR_DEV_HI) || n >= ERR_DEV_POS_LO)
            r[EVT_DEV_POS] = 1'b1;
        if (n >= ERR_EXE_LO && n <= ERR_EXE_HI)
            r[EVT_EXE_POS] = 1'b1;
        return r;
    endfunction

    // Registers and next values
    logic [7:0] standard_event_latch;
    logic [7:0] next_event;
    logic [7:0] sre;
    logic [7:0] next_sre;
    logic [7:0] ese;
    logic [7:0] next_ese;
    logic       request_service_flag;
    logic       next_rqs;
    logic       mss_q;
    logic       next_resp_valid;
    logic [7:0] next_resp_data;
    logic [7:0] next_status;
    logic       next_srq;
    logic       next_clear;

    // Combinational helpers
    logic [7:0] events_now;
    logic [7:0] summary_status_byte;
    logic       standard_event_summary_bit;
    logic       master_summary_bit;
    logic       is_cls;
    logic       is_spoll;
    logic       opc_done;

    // Checks below share this clock and reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------
    // Pending operation tracker
    // ------------------------------------------------------------
    sbes_pending u_pending (
        .clk             (clk),
        .rst_n           (rst_n),
        .auto_count_on   (auto_count_on),
        .stats_on        (stats_on),
        .func_tot_peak   (func_tot_peak),
        .meas_start      (meas_start),
        .meas_end        (meas_end),
        .block_start     (block_start),
        .block_last_done (block_last_done),
        .opc_cmd         (cmd_valid && cmd_code == SBES_CMD_OPC),
        .cls_cmd         (cmd_valid && cmd_code == SBES_CMD_CLS),
        .pending         (pending_op),
        .opc_done        (opc_done)
    );

    // ------------------------------------------------------------
    // Live summary bits
    // ------------------------------------------------------------
    always_comb
    begin
        is_cls   = cmd_valid && cmd_code == SBES_CMD_CLS;
        is_spoll = cmd_valid && cmd_code == SBES_CMD_SPOLL;
        standard_event_summary_bit      = |(standard_event_latch & ese);
        summary_status_byte                = 8'h00;
        summary_status_byte[STB_QUES_POS]  = ques_summary;
        summary_status_byte[STB_MSG_POS]   = queue_not_empty;
        summary_status_byte[STB_EVT_POS]   = standard_event_summary_bit;
        summary_status_byte[STB_OPER_POS]  = oper_summary;
        master_summary_bit = |(summary_status_byte & sre & SRE_USED_MASK);
    end

    // ------------------------------------------------------------
    // Event collection for the standard event latch
    // ------------------------------------------------------------
    always_comb
    begin
        events_now = 8'h00;
        if (err_valid)
            events_now = err_class(err_num);
        if (queue_err)
            events_now[EVT_QRY_POS] = 1'b1;
        if (command_err)
            events_now[EVT_CMD_POS] = 1'b1;
        if (opc_done)
            events_now[EVT_OPC_POS] = 1'b1;
        events_now = events_now & EVT_USED_MASK;
    end

    // ------------------------------------------------------------
    // Next register values
    // ------------------------------------------------------------
    always_comb
    begin
        next_event      = standard_event_latch | events_now;
        next_sre        = sre;
        next_ese        = ese;
        next_resp_valid = 1'b0;
        next_resp_data  = 8'h00;
        next_clear      = 1'b0;
        if (cmd_valid)
        begin
            case (cmd_code)
                SBES_CMD_CLS:
                begin
                    // New events this cycle survive the clear
                    next_event = events_now;
                    next_clear = 1'b1;
                end
                SBES_CMD_SRE_W:
                    next_sre = cmd_data & SRE_USED_MASK;
                SBES_CMD_SRE_R:
                begin
                    next_resp_valid = 1'b1;
                    next_resp_data  = sre;
                end
                SBES_CMD_ESE_W:
                    next_ese = cmd_data & EVT_USED_MASK;
                SBES_CMD_ESE_R:
                begin
                    next_resp_valid = 1'b1;
                    next_resp_data  = ese;
                end
                SBES_CMD_ESR_R:
                begin
                    next_resp_valid = 1'b1;
                    next_resp_data  = standard_event_latch;
                    next_event      = events_now;
                end
                SBES_CMD_STB_R:
                begin
                    next_resp_valid = 1'b1;
                    next_resp_data  = summary_status_byte;
                    next_resp_data[STB_SRV_POS] = master_summary_bit;
                end
                SBES_CMD_SPOLL:
                begin
                    next_resp_valid = 1'b1;
                    next_resp_data  = summary_status_byte;
                    next_resp_data[STB_SRV_POS] = request_service_flag;
                end
                default:
                begin
                    next_resp_valid = 1'b0;
                end
            endcase
        end
    end

    // Request flag: a new request wins over a poll in the same cycle
    always_comb
    begin
        next_rqs = request_service_flag;
        if (is_spoll || is_cls)
            next_rqs = 1'b0;
        if (master_summary_bit && !mss_q)
            next_rqs = 1'b1;
        next_srq    = master_summary_bit;
        next_status = summary_status_byte;
        next_status[STB_SRV_POS] = master_summary_bit;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            standard_event_latch <= EVT_RESET;
            sre                  <= SRE_RESET;
            ese                  <= ESE_RESET;
            request_service_flag                  <= 1'b0;
            mss_q                <= 1'b0;
            resp_valid           <= 1'b0;
            resp_data            <= 8'h00;
            status_byte          <= 8'h00;
            service_request      <= 1'b0;
            clear_status         <= 1'b0;
        end
        else
        begin
            standard_event_latch <= next_event;
            sre                  <= next_sre;
            ese                  <= next_ese;
            request_service_flag                  <= next_rqs;
            mss_q                <= master_summary_bit;
            resp_valid           <= next_resp_valid;
            resp_data            <= next_resp_data;
            status_byte          <= next_status;
            service_request      <= next_srq;
            clear_status         <= next_clear;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Follow checks skip the first edge after reset, where inputs may already differ
    ques_follow_a: assert property ($past(rst_n) |->
        status_byte[STB_QUES_POS] == $past(ques_summary))
        else $error("questionable summary bit mismatch");
    msg_follow_a: assert property ($past(rst_n) |->
        status_byte[STB_MSG_POS] == $past(queue_not_empty))
        else $error("message available bit mismatch");
    esb_summary_a: assert property ($past(rst_n) |->
        status_byte[STB_EVT_POS] == |($past(standard_event_latch) & $past(ese)))
        else $error("standard event summary mismatch");
    oper_follow_a: assert property ($past(rst_n) |->
        status_byte[STB_OPER_POS] == $past(oper_summary))
        else $error("operation summary bit mismatch");
    spoll_clears_a: assert property (
        (cmd_valid && cmd_code == SBES_CMD_SPOLL && !(master_summary_bit && !mss_q))
        |=> resp_valid && resp_data[STB_SRV_POS] == $past(request_service_flag) && !request_service_flag)
        else $error("serial poll did not report and clear request flag");
    stb_query_a: assert property (
        (cmd_valid && cmd_code == SBES_CMD_STB_R)
        |=> resp_valid && resp_data == status_byte && request_service_flag == $past(request_service_flag)
            || ($past(master_summary_bit) && !$past(mss_q)))
        else $error("status query answer wrong");
    unused_low_a: assert property (status_byte[2:0] == 3'h0)
        else $error("unused status bits set");
    cls_clears_a: assert property (
        (cmd_valid && cmd_code == SBES_CMD_CLS && events_now == 8'h00)
        |=> standard_event_latch == 8'h00 && clear_status
            ##1 clear_status == $past(is_cls))
        else $error("clear status left events");
    sre_zero_a: assert property (
        (cmd_valid && cmd_code == SBES_CMD_SRE_W && cmd_data == 8'h00)
        |=> sre == 8'h00 ##1 !service_request)
        else $error("zero enable mask still requests service");
    unused_evt_a: assert property (
        standard_event_latch[1] == 1'b0 && standard_event_latch[6] == 1'b0)
        else $error("unused event bit set");
    esr_read_a: assert property (
        (cmd_valid && cmd_code == SBES_CMD_ESR_R)
        |=> resp_data == $past(standard_event_latch)
            && standard_event_latch == $past(events_now))
        else $error("event latch read did not clear");
    err_class_a: assert property (
        (err_valid && $signed(err_num) == -16'sd250 && !is_cls
         && !(cmd_valid && cmd_code == SBES_CMD_ESR_R))
        |=> standard_event_latch[EVT_EXE_POS])
        else $error("execution error not latched");
    srq_level_a: assert property ($past(rst_n) |->
        service_request == $past(master_summary_bit))
        else $error("service request does not follow summary");

endmodule

// ==== verilog/sbes_pending.sv ====
// Pending-operation tracker and operation-complete generator.
// Assumes measurement start/end strobes are single-cycle pulses.
`timescale 1ns/10ps
module sbes_pending
    import sbes_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Measurement setup levels
    input  wire logic auto_count_on,
    input  wire logic stats_on,
    input  wire logic func_tot_peak,
    // Measurement progress strobes
    input  wire logic meas_start,
    input  wire logic meas_end,
    input  wire logic block_start,
    input  wire logic block_last_done,
    // Command strobes
    input  wire logic opc_cmd,
    input  wire logic cls_cmd,
    // Results
    output logic      pending,
    output logic      opc_done
);

    typedef enum logic {OPC_IDLE, OPC_WAIT} sbes_opc_t;

    sbes_opc_t state;
    sbes_opc_t next_state;
    logic      next_pending;
    logic      next_opc_done;
    logic      block_mode;
    logic      falls;

    // ------------------------------------------------------------
    // Pending condition and completion detect
    // ------------------------------------------------------------
    always_comb
    begin
        block_mode    = auto_count_on && stats_on && !func_tot_peak;
        next_pending  = pending;
        if (block_mode)
        begin
            if (block_start)
                next_pending = 1'b1;
            else if (block_last_done)
                next_pending = 1'b0;
        end
        else
        begin
            if (meas_start)
                next_pending = 1'b1;
            else if (meas_end)
                next_pending = 1'b0;
        end
        falls         = pending && !next_pending;
        next_state    = state;
        next_opc_done = 1'b0;
        case (state)
            OPC_IDLE:
            begin
                if (opc_cmd && (!pending || falls))
                    next_opc_done = 1'b1;
                else if (opc_cmd)
                    next_state = OPC_WAIT;
            end
            OPC_WAIT:
            begin
                if (falls)
                begin
                    next_opc_done = 1'b1;
                    next_state    = OPC_IDLE;
                end
                else if (cls_cmd)
                    next_state = OPC_IDLE;
            end
            default: next_state = OPC_IDLE;
        endcase
    end

    // Registers
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state    <= OPC_IDLE;
            pending  <= 1'b0;
            opc_done <= 1'b0;
        end
        else
        begin
            state    <= next_state;
            pending  <= next_pending;
            opc_done <= next_opc_done;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    opc_idle_now_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state == OPC_IDLE && opc_cmd && !pending) |=> opc_done)
        else $error("operation complete not set while idle");
    opc_after_fall_a: assert property (@(posedge clk) disable iff (!rst_n)
        opc_done |-> $past(pending) || $past(opc_cmd))
        else $error("operation complete without cause");

endmodule

// ==== verilog/sbes_pkg.sv ====
// Status byte and standard event summary: shared constants and types.
// Assumes one clock domain; commands arrive as decoded one-cycle strobes.
package sbes_pkg;

    // ------------------------------------------------------------
    // Status byte field positions
    // ------------------------------------------------------------
    localparam int STB_QUES_POS  = 3;
    localparam int STB_MSG_POS   = 4;
    localparam int STB_EVT_POS   = 5;
    localparam int STB_SRV_POS   = 6;
    localparam int STB_OPER_POS  = 7;

    // ------------------------------------------------------------
    // Standard event latch field positions
    // ------------------------------------------------------------
    localparam int EVT_OPC_POS   = 0;
    localparam int EVT_QRY_POS   = 2;
    localparam int EVT_DEV_POS   = 3;
    localparam int EVT_EXE_POS   = 4;
    localparam int EVT_CMD_POS   = 5;
    localparam int EVT_PON_POS   = 7;

    // ------------------------------------------------------------
    // Writable bit masks and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] SRE_USED_MASK = 8'hB8;
    localparam logic [7:0] EVT_USED_MASK = 8'hBD;
    localparam logic [7:0] SRE_RESET     = 8'h00;
    localparam logic [7:0] ESE_RESET     = 8'h00;
    localparam logic [7:0] EVT_RESET     = 8'h80;

    // ------------------------------------------------------------
    // Error number classes (inclusive bounds)
    // ------------------------------------------------------------
    localparam logic signed [15:0] ERR_QRY_LO = -16'sd499;
    localparam logic signed [15:0] ERR_QRY_HI = -16'sd400;
    localparam logic signed [15:0] ERR_DEV_LO = -16'sd399;
    localparam logic signed [15:0] ERR_DEV_HI = -16'sd300;
    localparam logic signed [15:0] ERR_EXE_LO = -16'sd299;
    localparam logic signed [15:0] ERR_EXE_HI = -16'sd200;
    localparam logic signed [15:0] ERR_DEV_POS_LO = 16'sd2000;

    // ------------------------------------------------------------
    // Decoded common commands
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        SBES_CMD_CLS,
        SBES_CMD_SRE_W,
        SBES_CMD_SRE_R,
        SBES_CMD_ESE_W,
        SBES_CMD_ESE_R,
        SBES_CMD_ESR_R,
        SBES_CMD_STB_R,
        SBES_CMD_SPOLL,
        SBES_CMD_OPC
    } sbes_cmd_t;

endpackage
